// >>> logic/bit_period_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_flags_map.svh"
// counts limit*16 bit periods while armed, one pulse, no repeat
module bit_period_timer
#(
	parameter int unsigned LIMIT_WIDTH = 8,
	parameter int unsigned STEP_BITS = `TIMEOUT_STEP_BITS
)
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic arm,
	input wire logic bit_tick,
	input wire logic [LIMIT_WIDTH-1:0] limit,
	output logic expired
);
	localparam int unsigned CW = LIMIT_WIDTH + STEP_BITS;
	radio_flags_pkg::timer_state_t state_q;
	logic [CW-1:0] count_q; // bit periods elapsed
	logic [CW-1:0] last; // final count before expiry
	logic at_end;
	assign last = {limit, {STEP_BITS{1'b0}}} - CW'(1);
	assign at_end = bit_tick && (count_q == last);
	// ****************************************
	// sequencing
	// ****************************************
	// a zero limit never leaves idle: timeout disabled
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			state_q <= radio_flags_pkg::TMR_IDLE;
		else
			case (state_q)
				radio_flags_pkg::TMR_IDLE:
					if (arm && limit != '0)
						state_q <= radio_flags_pkg::TMR_RUN;
				radio_flags_pkg::TMR_RUN:
					if (!arm)
						state_q <= radio_flags_pkg::TMR_IDLE;
					else if (at_end)
						state_q <= radio_flags_pkg::TMR_DONE;
				radio_flags_pkg::TMR_DONE:
					if (!arm)
						state_q <= radio_flags_pkg::TMR_IDLE;
				default:
					state_q <= radio_flags_pkg::TMR_IDLE;
			endcase
	end
	// counter only advances on bit period enables
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			count_q <= '0;
		else if (state_q != radio_flags_pkg::TMR_RUN || !arm)
			count_q <= '0;
		else if (bit_tick)
			count_q <= count_q + CW'(1);
	end
	// expiry pulse
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			expired <= 1'b0;
		else
			expired <= (state_q == radio_flags_pkg::TMR_RUN) && arm && at_end;
	end
endmodule
`default_nettype wire

// >>> logic/clock_out_divider.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_flags_map.svh"
// clock output pin: divided reference, rc clock, or off
module clock_out_divider
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [2:0] select,
	input wire logic rc_clock,
	output logic pin,
	output logic rc_enable
);
	logic [4:0] count_q; // free running divider
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			count_q <= 5'h00;
		else
			count_q <= count_q + 5'h01;
	end
	// output from a flop: code 0 can only reach half rate
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			pin <= 1'b0;
		else
			case (select)
				`CLOCK_SELECT_RC:
					pin <= rc_clock;
				`CLOCK_SELECT_OFF:
					pin <= 1'b0;
				3'h0:
					pin <= ~pin;
				default:
					pin <= count_q[select - 3'h1];
			endcase
	end
	// rc oscillator enabled only while selected
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			rc_enable <= 1'b0;
		else
			rc_enable <= (select == `CLOCK_SELECT_RC);
	end
endmodule
`default_nettype wire

// >>> logic/radio_flags_map.svh
`ifndef RADIO_FLAGS_MAP_SVH
`define RADIO_FLAGS_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define OFS_PIN_MAP_LOW 7'h25
`define OFS_PIN_MAP_HIGH 7'h26
`define OFS_FLAGS_MODE 7'h27
`define OFS_FLAGS_FIFO 7'h28
`define OFS_STRENGTH_THRESHOLD 7'h29
`define OFS_START_TIMEOUT 7'h2A
`define OFS_POST_TIMEOUT 7'h2B
// ****************************************
// field positions
// ****************************************
`define BIT_RSSI_FLAG 3
`define BIT_MATCH_FLAG 0
`define BIT_OVERRUN_FLAG 4
// ****************************************
// reset values
// ****************************************
`define RST_PIN_MAP 8'h00
`define RST_STRENGTH_THRESHOLD 8'hE4
`define RST_TIMEOUT 8'h00
`define RST_CLOCK_SELECT 3'h7
// ****************************************
// codes and counts
// ****************************************
`define CLOCK_SELECT_RC 3'h6
`define CLOCK_SELECT_OFF 3'h7
`define FIFO_FULL_COUNT 7'h42
`define TIMEOUT_STEP_BITS 4
`endif

// >>> logic/radio_flags_pkg.sv
package radio_flags_pkg;
	// operating mode, one-hot
	typedef enum logic [4:0]
	{
		MODE_SLEEP = 5'h01,
		MODE_STANDBY = 5'h02,
		MODE_SYNTH = 5'h04,
		MODE_RX = 5'h08,
		MODE_TX = 5'h10
	} op_mode_t;
	// timeout timer states, one-hot
	typedef enum logic [2:0]
	{
		TMR_IDLE = 3'h1,
		TMR_RUN = 3'h2,
		TMR_DONE = 3'h4
	} timer_state_t;
endpackage

// >>> logic/radio_status_flags.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "radio_flags_map.svh"
// Overview of operation
// - mode ready set on reach, cleared on change
// - receive ready after rx chain settles
// - transmit ready after amplifier ramp
// - lock flag follows pll in fs/rx/tx
// - rssi flag above threshold, w1c, rx only
// - timeout flag, cleared leaving rx or empty
// - intermediate flag follows intermediate mode
// - match flag, w1c only in continuous mode
// - full flag exactly at 66 bytes
// - not-empty flag with any byte
// - level flag strictly above threshold
// - overrun flag set outside sleep
// - writing one clears flags and fifo
// - sent flag in tx, cleared leaving tx
// - payload ready after last byte, crc gated
// - checksum good flag, cleared on empty
// - threshold register resets to 0xE4
// - entry timeout, value times 16 bits
// - post-trigger timeout, value times 16 bits
// - clock output divider, rc, off
// - six two-bit pin selects, reset zero
// - strength is half-dB magnitude
module radio_status_flags
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire radio_flags_pkg::op_mode_t op_mode,
	input wire logic xo_running,
	input wire logic pll_locked,
	input wire logic rssi_sampling,
	input wire logic pa_ramp_done,
	input wire logic rx_chain_settled,
	input wire logic [7:0] measured_strength,
	input wire logic intermediate_active,
	input wire logic match_detected,
	input wire logic packet_mode,
	input wire logic [6:0] fifo_count,
	input wire logic [6:0] queue_level_trigger,
	input wire logic overrun_event,
	input wire logic frame_sent_event,
	input wire logic last_byte_event,
	input wire logic checksum_pass,
	input wire logic crc_enable,
	input wire logic keep_bad_checksum_frames,
	input wire logic bit_tick,
	input wire logic rc_clock,
	output logic [5:0] pin_out,
	output logic clock_output_pin,
	output logic rc_osc_enable,
	output logic fifo_flush
);
	// ****************************************
	// registers
	// ****************************************
	logic [7:0] pin_map_low_q; // pins 0..3 selects
	logic [3:0] pin_map_high_q; // pins 4..5 selects
	logic [2:0] clock_out_divider_select_q;
	logic [7:0] strength_trigger_level_q;
	logic [7:0] receive_entry_timeout_q;
	logic [7:0] post_trigger_timeout_q;
	radio_flags_pkg::op_mode_t mode_prev_q; // last mode seen
	logic requested_state_reached_q;
	logic receive_ready_flag_q;
	logic transmit_ready_flag_q;
	logic synth_locked_flag_q;
	logic rssi_flag_q;
	logic timeout_flag_q;
	logic intermediate_state_flag_q;
	logic preamble_word_match_flag_q;
	logic queue_full_flag_q;
	logic queue_has_bytes_flag_q;
	logic queue_above_threshold_flag_q;
	logic queue_overflow_flag_q;
	logic frame_transmitted_flag_q;
	logic frame_received_flag_q;
	logic checksum_good_flag_q;
	logic rssi_seen_q; // threshold crossed in this rx visit
	// ****************************************
	// decode
	// ****************************************
	logic in_rx, in_tx, mode_changed, emptied;
	logic wr_flags_mode, wr_flags_fifo, overrun_clear;
	logic entry_expired, post_expired;
	logic strength_over, payload_done;
	logic [7:0] flags_mode, flags_fifo, rd_d;
	logic [15:0] flag_word;
	logic [11:0] pin_map_all; // both select registers, pin 0 at the top
	assign in_rx = (op_mode == radio_flags_pkg::MODE_RX);
	assign in_tx = (op_mode == radio_flags_pkg::MODE_TX);
	assign mode_changed = (op_mode != mode_prev_q);
	// fifo drained: bytes were there, now none
	assign emptied = queue_has_bytes_flag_q && (fifo_count == 7'h00);
	assign wr_flags_mode = reg_write && reg_addr == `OFS_FLAGS_MODE;
	assign wr_flags_fifo = reg_write && reg_addr == `OFS_FLAGS_FIFO;
	assign overrun_clear = wr_flags_fifo && reg_wdata[`BIT_OVERRUN_FLAG];
	// magnitude compare: larger value means weaker signal
	assign strength_over = measured_strength > strength_trigger_level_q;
	// bad crc frames are dropped unless kept
	assign payload_done = last_byte_event && (!crc_enable || keep_bad_checksum_frames || checksum_pass);
	assign flags_mode = {requested_state_reached_q, receive_ready_flag_q, transmit_ready_flag_q,
		synth_locked_flag_q, rssi_flag_q, timeout_flag_q, intermediate_state_flag_q,
		preamble_word_match_flag_q};
	assign flags_fifo = {queue_full_flag_q, queue_has_bytes_flag_q, queue_above_threshold_flag_q,
		queue_overflow_flag_q, frame_transmitted_flag_q, frame_received_flag_q,
		checksum_good_flag_q, 1'b0};
	assign flag_word = {flags_mode, flags_fifo};
	// one vector keeps every pin's slice in range
	assign pin_map_all = {pin_map_low_q, pin_map_high_q};
	// ****************************************
	// helpers
	// ****************************************
	// has the requested mode been reached
	function automatic logic mode_reached(input radio_flags_pkg::op_mode_t m, input logic xo,
		input logic lock, input logic rssi_go, input logic ramp);
		case (m)
			radio_flags_pkg::MODE_SLEEP: mode_reached = 1'b1;
			radio_flags_pkg::MODE_STANDBY: mode_reached = xo;
			radio_flags_pkg::MODE_SYNTH: mode_reached = lock;
			radio_flags_pkg::MODE_RX: mode_reached = rssi_go;
			radio_flags_pkg::MODE_TX: mode_reached = ramp;
			default: mode_reached = 1'b0;
		endcase
	endfunction
	// flag word index for a pin select; two tables by data mode
	function automatic logic [3:0] pin_source(input int unsigned pin, input logic [1:0] code,
		input logic pkt);
		logic [15:0] row;
		row = 16'h0000;
		case (pin)
			0: row = pkt ? 16'hF8A9 : 16'h8D2F;
			1: row = pkt ? 16'hA6D7 : 16'h8DC4;
			2: row = pkt ? 16'hF806 : 16'hF806;
			3: row = pkt ? 16'hFC09 : 16'hF8DC;
			4: row = pkt ? 16'hCBA9 : 16'hCBAD;
			default: row = pkt ? 16'hF9DE : 16'hF9DE;
		endcase
		pin_source = row[{code, 2'b00} +: 4];
	endfunction
	// ****************************************
	// register writes
	// ****************************************
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			pin_map_low_q <= `RST_PIN_MAP;
			pin_map_high_q <= 4'h0;
			clock_out_divider_select_q <= `RST_CLOCK_SELECT;
			strength_trigger_level_q <= `RST_STRENGTH_THRESHOLD;
			receive_entry_timeout_q <= `RST_TIMEOUT;
			post_trigger_timeout_q <= `RST_TIMEOUT;
		end
		else if (reg_write)
			case (reg_addr)
				`OFS_PIN_MAP_LOW:
					pin_map_low_q <= reg_wdata;
				`OFS_PIN_MAP_HIGH:
				begin
					pin_map_high_q <= reg_wdata[7:4];
					clock_out_divider_select_q <= reg_wdata[2:0];
				end
				`OFS_STRENGTH_THRESHOLD:
					strength_trigger_level_q <= reg_wdata;
				`OFS_START_TIMEOUT:
					receive_entry_timeout_q <= reg_wdata;
				`OFS_POST_TIMEOUT:
					post_trigger_timeout_q <= reg_wdata;
				default:
					pin_map_low_q <= pin_map_low_q;
			endcase
	end
	// ****************************************
	// mode flags
	// ****************************************
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			mode_prev_q <= radio_flags_pkg::MODE_SLEEP;
		else
			mode_prev_q <= op_mode;
	end
	// reset shows ready: device wakes already in its mode
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			requested_state_reached_q <= 1'b1;
		else if (mode_changed)
			requested_state_reached_q <= 1'b0;
		else if (mode_reached(op_mode, xo_running, pll_locked, rssi_sampling, pa_ramp_done))
			requested_state_reached_q <= 1'b1;
	end
	// rx/tx readiness and lock
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			receive_ready_flag_q <= 1'b0;
			transmit_ready_flag_q <= 1'b0;
			synth_locked_flag_q <= 1'b0;
			intermediate_state_flag_q <= 1'b0;
		end
		else
		begin
			receive_ready_flag_q <= in_rx && !mode_changed && (receive_ready_flag_q || rx_chain_settled);
			transmit_ready_flag_q <= in_tx && !mode_changed && (transmit_ready_flag_q || pa_ramp_done);
			synth_locked_flag_q <= pll_locked && (in_rx || in_tx ||
				op_mode == radio_flags_pkg::MODE_SYNTH);
			intermediate_state_flag_q <= intermediate_active;
		end
	end
	// ****************************************
	// receive flags
	// ****************************************
	// set wins over software clear; leaving rx always clears
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			rssi_flag_q <= 1'b0;
		else if (!in_rx)
			rssi_flag_q <= 1'b0;
		else if (strength_over)
			rssi_flag_q <= 1'b1;
		else if (wr_flags_mode && reg_wdata[`BIT_RSSI_FLAG])
			rssi_flag_q <= 1'b0;
	end
	// tracks the crossing itself, immune to software clear
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			rssi_seen_q <= 1'b0;
		else if (!in_rx || mode_changed)
			rssi_seen_q <= 1'b0;
		else if (strength_over)
			rssi_seen_q <= 1'b1;
	end
	// match flag: software clear only in continuous mode
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			preamble_word_match_flag_q <= 1'b0;
		else if (!in_rx)
			preamble_word_match_flag_q <= 1'b0;
		else if (match_detected)
			preamble_word_match_flag_q <= 1'b1;
		else if (emptied || overrun_clear || (!packet_mode && wr_flags_mode && reg_wdata[`BIT_MATCH_FLAG]))
			preamble_word_match_flag_q <= 1'b0;
	end
	// timeout: expiry beats the empty and overrun clears; leaving rx beats expiry
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			timeout_flag_q <= 1'b0;
		else if (!in_rx)
			timeout_flag_q <= 1'b0;
		else if (entry_expired || post_expired)
			timeout_flag_q <= 1'b1;
		else if (emptied || overrun_clear)
			timeout_flag_q <= 1'b0;
	end
	// entry timer stops at the first crossing
	bit_period_timer entry_timer
	(
		.clock(clock),
		.rstn(rstn),
		.arm(in_rx && !mode_changed && !rssi_seen_q && !strength_over),
		.bit_tick(bit_tick),
		.limit(receive_entry_timeout_q),
		.expired(entry_expired)
	);
	// post-trigger timer stops when payload is ready
	bit_period_timer post_timer
	(
		.clock(clock),
		.rstn(rstn),
		.arm(in_rx && rssi_seen_q && !frame_received_flag_q && !payload_done),
		.bit_tick(bit_tick),
		.limit(post_trigger_timeout_q),
		.expired(post_expired)
	);
	// ****************************************
	// fifo and packet flags
	// ****************************************
	// levels follow the fifo count one cycle late
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			queue_full_flag_q <= 1'b0;
			queue_has_bytes_flag_q <= 1'b0;
			queue_above_threshold_flag_q <= 1'b0;
		end
		else
		begin
			queue_full_flag_q <= (fifo_count == `FIFO_FULL_COUNT);
			queue_has_bytes_flag_q <= (fifo_count != 7'h00);
			queue_above_threshold_flag_q <= (fifo_count > queue_level_trigger);
		end
	end
	// overrun: a new overrun beats the clearing write
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			queue_overflow_flag_q <= 1'b0;
		else if (overrun_event && op_mode != radio_flags_pkg::MODE_SLEEP)
			queue_overflow_flag_q <= 1'b1;
		else if (overrun_clear)
			queue_overflow_flag_q <= 1'b0;
	end
	// one-cycle flush request to the fifo
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			fifo_flush <= 1'b0;
		else
			fifo_flush <= overrun_clear;
	end
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			frame_transmitted_flag_q <= 1'b0;
		else if (!in_tx)
			frame_transmitted_flag_q <= 1'b0;
		else if (frame_sent_event)
			frame_transmitted_flag_q <= 1'b1;
	end
	// payload and crc flags end with the fifo contents
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			frame_received_flag_q <= 1'b0;
			checksum_good_flag_q <= 1'b0;
		end
		else
		begin
			if (in_rx && payload_done)
				frame_received_flag_q <= 1'b1;
			else if (emptied || overrun_clear)
				frame_received_flag_q <= 1'b0;
			if (in_rx && last_byte_event && crc_enable && checksum_pass)
				checksum_good_flag_q <= 1'b1;
			else if (emptied || overrun_clear)
				checksum_good_flag_q <= 1'b0;
		end
	end
	// ****************************************
	// pins and read port
	// ****************************************
	// each pin picks one registered flag, except constant zero for pin 2 code 1 and for pin 3 code 1 in packet mode
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			pin_out <= 6'h00;
		else
			for (int unsigned p = 0; p < 6; p++)
				pin_out[p] <= flag_word[pin_source(p, pin_map_all[11 - 2 * p -: 2], packet_mode)];
	end
	always_comb
	begin
		case (reg_addr)
			`OFS_PIN_MAP_LOW: rd_d = pin_map_low_q;
			`OFS_PIN_MAP_HIGH: rd_d = {pin_map_high_q, 1'b0, clock_out_divider_select_q};
			`OFS_FLAGS_MODE: rd_d = flags_mode;
			`OFS_FLAGS_FIFO: rd_d = flags_fifo;
			`OFS_STRENGTH_THRESHOLD: rd_d = strength_trigger_level_q;
			`OFS_START_TIMEOUT: rd_d = receive_entry_timeout_q;
			`OFS_POST_TIMEOUT: rd_d = post_trigger_timeout_q;
			default: rd_d = 8'h00;
		endcase
	end
	// read data valid only in the cycle after the strobe
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else if (reg_read)
			reg_rdata <= rd_d;
		else
			reg_rdata <= 8'h00;
	end
	clock_out_divider clock_out
	(
		.clock(clock),
		.rstn(rstn),
		.select(clock_out_divider_select_q),
		.rc_clock(rc_clock),
		.pin(clock_output_pin),
		.rc_enable(rc_osc_enable)
	);
	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence flush_pulse;
		fifo_flush ##1 !fifo_flush;
	endsequence
	chk_full_exact: assert property ((fifo_count == `FIFO_FULL_COUNT) |=> queue_full_flag_q)
		else $error("full flag missed 66 bytes");
	chk_level_strict: assert property ((fifo_count == queue_level_trigger) |=> !queue_above_threshold_flag_q)
		else $error("level flag set on equality");
	chk_ready_change: assert property (mode_changed |=> !requested_state_reached_q)
		else $error("mode ready kept over mode change");
	chk_rx_ready_leave: assert property ($fell(in_rx) |=> !receive_ready_flag_q)
		else $error("receive ready kept outside rx");
	chk_tx_ready_leave: assert property (!in_tx |=> !transmit_ready_flag_q)
		else $error("transmit ready kept outside tx");
	chk_lock_follow: assert property (in_rx && !pll_locked |=> !synth_locked_flag_q)
		else $error("lock flag set while unlocked");
	chk_rssi_set: assert property (in_rx && strength_over |=> rssi_flag_q)
		else $error("rssi flag missed threshold");
	chk_overrun_set: assert property (overrun_event && op_mode != radio_flags_pkg::MODE_SLEEP
		|=> queue_overflow_flag_q)
		else $error("overrun flag missed");
	chk_overrun_flush: assert property (overrun_clear && !overrun_event |=> flush_pulse
		and !frame_received_flag_q)
		else $error("overrun clear did not flush");
	chk_timeout_set: assert property (in_rx && entry_expired |=> timeout_flag_q)
		else $error("timeout flag missed expiry");
	chk_threshold_read: assert property (reg_read && reg_addr == `OFS_STRENGTH_THRESHOLD
		&& !reg_write |=> reg_rdata == strength_trigger_level_q)
		else $error("threshold read wrong");
endmodule
`default_nettype wire

// >>> verif/fifo_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far-side fifo occupancy model
// ****************************************
module fifo_far_model
#(
	parameter int unsigned DEPTH = 66
)
(
	input wire logic clock,
	input wire logic rstn,
	input wire logic push,
	input wire logic fifo_flush,
	output logic [6:0] fifo_count,
	output logic overrun_event
);
	// byte count; a push into a full queue is lost and reported
	always_ff @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			fifo_count <= 7'h00;
			overrun_event <= 1'b0;
		end
		else if (fifo_flush)
		begin
			// emptied at once so the queue is usable on the next cycle
			fifo_count <= 7'h00;
			overrun_event <= 1'b0;
		end
		else
		begin
			overrun_event <= push && (fifo_count == 7'(DEPTH));
			if (push && (fifo_count < 7'(DEPTH)))
				fifo_count <= fifo_count + 7'h01;
		end
	end
endmodule
`default_nettype wire

// >>> verif/radio_status_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "radio_flags_map.svh"
module radio_status_flags_tb;
	// ****************************************
	// stimulus and observed signals
	// ****************************************
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic [6:0] reg_addr = 7'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0, reg_read = 1'b0, push = 1'b0, bit_tick = 1'b0;
	radio_flags_pkg::op_mode_t op_mode = radio_flags_pkg::MODE_STANDBY;
	logic xo_running = 1'b1, pll_locked = 1'b0, rssi_sampling = 1'b0, pa_ramp_done = 1'b0;
	logic rx_chain_settled = 1'b0, intermediate_active = 1'b0, match_detected = 1'b0;
	logic packet_mode = 1'b1, frame_sent_event = 1'b0, last_byte_event = 1'b0, rc_clock = 1'b0;
	logic checksum_pass = 1'b0, crc_enable = 1'b1, keep_bad_checksum_frames = 1'b0;
	logic [7:0] measured_strength = 8'h00;
	logic [6:0] queue_level_trigger = 7'h05; // level compare point
	wire logic [7:0] reg_rdata;
	wire logic [5:0] pin_out;
	wire logic [6:0] fifo_count;
	wire logic clock_output_pin, rc_osc_enable, fifo_flush, overrun_event;
	int mismatches = 0;
	int cmp_count = 0;
	int flush_seen = 0;
	logic [7:0] d;
	// free-running 250 MHz clock
	always #2 clock = ~clock;
	// counts flush pulses sent to the far side
	always @(posedge clock)
		if (fifo_flush === 1'b1)
			flush_seen++;
	radio_status_flags i_radio_status_flags (.clock, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
		.reg_rdata, .op_mode, .xo_running, .pll_locked, .rssi_sampling, .pa_ramp_done, .rx_chain_settled,
		.measured_strength, .intermediate_active, .match_detected, .packet_mode, .fifo_count,
		.queue_level_trigger, .overrun_event, .frame_sent_event, .last_byte_event, .checksum_pass,
		.crc_enable, .keep_bad_checksum_frames, .bit_tick, .rc_clock, .pin_out, .clock_output_pin,
		.rc_osc_enable, .fifo_flush);
	fifo_far_model i_fifo_far_model (.clock, .rstn, .push, .fifo_flush, .fifo_count, .overrun_event);
	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// one-cycle write strobe
	task automatic reg_wr(input logic [6:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic reg_rd(input logic [6:0] a, output logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		v = reg_rdata;
		@(posedge clock);
	endtask
	task automatic push_bytes(input int n);
		@(posedge clock);
		push <= 1'b1;
		repeat (n) @(posedge clock);
		push <= 1'b0;
	endtask
	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge clock);
			bit_tick <= 1'b1;
			@(posedge clock);
			bit_tick <= 1'b0;
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		reg_rd(`OFS_STRENGTH_THRESHOLD, d); check("threshold", d, 8'hE4);
		reg_rd(`OFS_START_TIMEOUT, d); check("entry timeout", d, 8'h00);
		reg_rd(`OFS_POST_TIMEOUT, d); check("post timeout", d, 8'h00);
		reg_rd(`OFS_PIN_MAP_LOW, d); check("pin map", d, 8'h00);
		reg_rd(`OFS_FLAGS_MODE, d); check("mode flags", d, 8'h80);
		reg_rd(7'h00, d); check("unmapped", d, 8'h00);
		check("clock pin off", {7'h00, clock_output_pin}, 8'h00);
	endtask
	// rc code enables the oscillator; unused bit 3 reads zero
	task automatic t_clock_select();
		logic prev;
		int n;
		n = 0;
		// divide by four: the pin changes every second clock
		reg_wr(`OFS_PIN_MAP_HIGH, 8'h02);
		repeat (2) @(posedge clock);
		prev = clock_output_pin;
		repeat (16)
		begin
			@(posedge clock);
			n += (clock_output_pin != prev);
			prev = clock_output_pin;
		end
		check("divide by 4", 8'(n), 8'h08);
		reg_wr(`OFS_PIN_MAP_HIGH, 8'h0E);
		reg_rd(`OFS_PIN_MAP_HIGH, d); check("clock select", d, 8'h06);
		check("rc enable", {7'h00, rc_osc_enable}, 8'h01);
		reg_wr(`OFS_PIN_MAP_HIGH, 8'h07);
		reg_rd(`OFS_PIN_MAP_HIGH, d); check("rc disable", {7'h00, rc_osc_enable}, 8'h00);
	endtask
	// default selects route the intermediate flag to pins 0, 3 and 4
	task automatic t_pins();
		intermediate_active <= 1'b1;
		repeat (3) @(posedge clock);
		check("pins default", {2'b00, pin_out}, 8'h19);
		reg_wr(`OFS_PIN_MAP_LOW, 8'h40);
		repeat (3) @(posedge clock);
		check("pin0 remapped", {2'b00, pin_out}, 8'h18);
		reg_wr(`OFS_PIN_MAP_LOW, 8'h00);
		intermediate_active <= 1'b0;
		repeat (3) @(posedge clock);
		check("pins idle", {2'b00, pin_out}, 8'h00);
	endtask
	// transmit ready and packet sent set in transmit; packet sent ends when leaving transmit
	task automatic t_transmit();
		op_mode <= radio_flags_pkg::MODE_TX;
		pa_ramp_done <= 1'b1;
		@(posedge clock);
		frame_sent_event <= 1'b1;
		@(posedge clock);
		frame_sent_event <= 1'b0;
		reg_rd(`OFS_FLAGS_MODE, d);
		check("tx ready", d & 8'hA0, 8'hA0);
		reg_rd(`OFS_FLAGS_FIFO, d);
		check("sent", d & 8'h08, 8'h08);
		op_mode <= radio_flags_pkg::MODE_STANDBY;
		pa_ramp_done <= 1'b0;
		reg_rd(`OFS_FLAGS_FIFO, d);
		check("sent left tx", d & 8'h08, 8'h00);
	endtask
	// threshold equality, full at 66, overrun, then clear by writing one
	task automatic t_fifo();
		push_bytes(5);
		reg_rd(`OFS_FLAGS_FIFO, d); check("level equal", d & 8'hF0, 8'h40);
		push_bytes(1);
		reg_rd(`OFS_FLAGS_FIFO, d); check("level above", d & 8'hF0, 8'h60);
		push_bytes(60);
		reg_rd(`OFS_FLAGS_FIFO, d); check("full", d & 8'hF0, 8'hE0);
		push_bytes(1);
		repeat (2) @(posedge clock);
		reg_rd(`OFS_FLAGS_FIFO, d); check("overrun", d & 8'hF0, 8'hF0);
		reg_wr(`OFS_FLAGS_FIFO, 8'h10);
		repeat (2) @(posedge clock);
		check("flush pulses", 8'(flush_seen), 8'h01);
		check("fifo count", {1'b0, fifo_count}, 8'h00);
		reg_rd(`OFS_FLAGS_FIFO, d); check("after clear", d, 8'h00);
	endtask
	// strength must exceed, not equal, the threshold; software clear
	task automatic t_rssi();
		op_mode <= radio_flags_pkg::MODE_RX;
		measured_strength <= 8'hE4;
		reg_rd(`OFS_FLAGS_MODE, d); check("rssi equal", d & 8'h08, 8'h00);
		measured_strength <= 8'hE5;
		reg_rd(`OFS_FLAGS_MODE, d); check("rssi above", d & 8'h08, 8'h08);
		measured_strength <= 8'h00;
		reg_wr(`OFS_FLAGS_MODE, 8'h08);
		reg_rd(`OFS_FLAGS_MODE, d); check("rssi cleared", d & 8'h08, 8'h00);
		op_mode <= radio_flags_pkg::MODE_STANDBY;
	endtask
	// limit one means sixteen bit periods after entering receive
	task automatic t_timeout();
		logic hit;
		hit = 1'b0;
		reg_wr(`OFS_START_TIMEOUT, 8'h01);
		op_mode <= radio_flags_pkg::MODE_RX;
		// let the entry timer arm before the first bit period
		repeat (2) @(posedge clock);
		ticks(15);
		reg_rd(`OFS_FLAGS_MODE, d); check("timeout early", d & 8'h04, 8'h00);
		ticks(1);
		for (int i = 0; i < 8 && !hit; i++)
		begin
			reg_rd(`OFS_FLAGS_MODE, d);
			hit = (d[2] === 1'b1);
		end
		check("timeout set", {7'h00, hit}, 8'h01);
		if (!hit)
			end_of_test();
		op_mode <= radio_flags_pkg::MODE_STANDBY;
		reg_rd(`OFS_FLAGS_MODE, d); check("timeout left rx", d & 8'h04, 8'h00);
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		t_reset();
		t_clock_select();
		t_pins();
		t_fifo();
		t_rssi();
		t_transmit();
		t_timeout();
		end_of_test();
	end
endmodule
`default_nettype wire
